/* File: verilog/mrs_cfg.svh */
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
// Register byte offsets
`define MRS_OFS_CTRL     12'h000
`define MRS_OFS_STATUS   12'h004
`define MRS_OFS_IRQ_STAT 12'h008
`define MRS_OFS_IRQ_MASK 12'h00c
// Control register fields
`define MRS_CTRL_ENABLE  0
`define MRS_CTRL_RESET   32'h0000_0001
// Interrupt status bit positions
`define MRS_EV_THERMAL   0
`define MRS_EV_ESTOP     1
`define MRS_EV_STOPPED   2
`define MRS_EV_REVERSE   3
// Debounce time
`define MRS_DEB_US       1000
`define MRS_CLK_MHZ      25
`endif

/* File: verilog/mrs_pkg.sv */
package mrs_pkg;
  typedef enum logic [2:0] {
    MRS_IDLE,
    MRS_RUN,
    MRS_RAMP_STOP,
    MRS_REV_DECEL,
    MRS_TRIP
  } mrs_state_t;

  // Debounced operator contacts
  typedef struct packed {
    logic thermal_ok;
    logic estop_ok;
    logic hold;
    logic run;
    logic digital_sel;
    logic reverse;
  } mrs_inputs_t;

  // Requests to the ramp and speed path
  typedef struct packed {
    logic drive_on;
    logic ramp_enable;
    logic ramp_to_zero;
    logic direction_rev;
    logic speed_src_digital;
    logic current_limit_step;
  } mrs_drive_t;
endpackage

/* File: verilog/mrs_sequencer.sv */
`timescale 1ns/100ps
`include "mrs_cfg.svh"
module mrs_sequencer #(
  parameter int DEB_CYCLES = `MRS_DEB_US * `MRS_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic        clk_en,
  // Operator contacts, asynchronous
  input  wire  logic        thermal_closed,
  input  wire  logic        estop_closed,
  input  wire  logic        hold_closed,
  input  wire  logic        run_closed,
  input  wire  logic        digital_select,
  input  wire  logic        reverse_select,
  // Jumpers and reference, static straps
  input  wire  logic        direction_source_jumper,
  input  wire  logic [1:0]  customer_output_select_jumper,
  input  wire  logic        ref_negative,
  input  wire  logic        ref_on_alt_terminal,
  // Ramp path feedback, same clock
  input  wire  logic        at_zero_speed,
  // Drive requests
  output logic              drive_on,
  output logic              ramp_enable,
  output logic              ramp_to_zero,
  output logic              direction_rev,
  output logic              speed_src_digital,
  output logic              current_limit_step,
  // Indications
  output logic              run_feedback,
  output logic              run_feedback_oe,
  output logic              thermal_fault,
  output logic              customer_out,
  output logic              customer_out_oe,
  // AXI4-Lite slave
  input  wire  logic [11:0] s_awaddr,
  input  wire  logic        s_awvalid,
  output logic              s_awready,
  input  wire  logic [31:0] s_wdata,
  input  wire  logic [3:0]  s_wstrb,
  input  wire  logic        s_wvalid,
  output logic              s_wready,
  output logic [1:0]        s_bresp,
  output logic              s_bvalid,
  input  wire  logic        s_bready,
  input  wire  logic [11:0] s_araddr,
  input  wire  logic        s_arvalid,
  output logic              s_arready,
  output logic [31:0]       s_rdata,
  output logic [1:0]        s_rresp,
  output logic              s_rvalid,
  input  wire  logic        s_rready,
  output logic              irq
);
  localparam int NIN = 6;
  localparam int DW  = $clog2(DEB_CYCLES + 1);

  // ==========================================================
  // State record
  typedef struct packed {
    logic [NIN-1:0]         s1;
    logic [NIN-1:0]         s2;
    logic [NIN-1:0]         deb;
    logic [NIN-1:0][DW-1:0] cnt;
    mrs_pkg::mrs_state_t    st;
    logic                   latched;
    logic                   dir;
    logic                   src;
    logic                   step;
    logic                   fault;
    mrs_pkg::mrs_drive_t    drv;
    logic                   fb;
    logic                   cout;
    logic                   coe;
    logic                   enable;
    logic [3:0]             ist;
    logic [3:0]             imask;
    logic                   irq;
    logic                   aw_ok;
    logic [11:0]            awa;
    logic                   w_ok;
    logic [31:0]            wd;
    logic [3:0]             ws;
    logic                   bv;
    logic [1:0]             br;
    logic                   rv;
    logic [31:0]            rd;
    logic [1:0]             rr;
  } mrs_regs_t;

  mrs_regs_t q_r;
  mrs_regs_t q_nxt;

  // Raw contacts gathered for the synchroniser
  logic [NIN-1:0] raw;
  assign raw = {thermal_closed, estop_closed, hold_closed,
                run_closed, digital_select, reverse_select};

  mrs_pkg::mrs_inputs_t din;
  assign din = mrs_pkg::mrs_inputs_t'(q_r.deb);

  // Read decode used by the read path
  function automatic logic [31:0] rd_word(input logic [11:0] a, input mrs_regs_t s);
    case (a)
      `MRS_OFS_CTRL:     rd_word = {31'h0, s.enable};
      `MRS_OFS_STATUS:   rd_word = {24'h0, s.fault, s.latched, s.dir, s.src,
                                    1'b0, s.st};
      `MRS_OFS_IRQ_STAT: rd_word = {28'h0, s.ist};
      `MRS_OFS_IRQ_MASK: rd_word = {28'h0, s.imask};
      default:           rd_word = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `MRS_OFS_CTRL) || (a == `MRS_OFS_STATUS) ||
             (a == `MRS_OFS_IRQ_STAT) || (a == `MRS_OFS_IRQ_MASK);
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic       can_run;
    logic       want_dir;
    logic [3:0] ev;
    logic       wr_go;
    q_nxt    = q_r;
    can_run  = 1'b0;
    want_dir = 1'b0;
    ev       = 4'h0;
    wr_go    = 1'b0;

    // Two-stage sync, then each contact must stay changed for DEB_CYCLES before it is taken
    q_nxt.s1 = raw;
    q_nxt.s2 = q_r.s1;
    for (int i = 0; i < NIN; i++) begin
      if (q_r.s2[i] == q_r.deb[i]) begin
        q_nxt.cnt[i] = '0;
      end else if (q_r.cnt[i] == DW'(DEB_CYCLES - 1)) begin
        q_nxt.deb[i] = q_r.s2[i];
        q_nxt.cnt[i] = '0;
      end else begin
        q_nxt.cnt[i] = q_r.cnt[i] + DW'(1);
      end
    end

    // Interlocks gate every path into running
    can_run = din.thermal_ok && din.estop_ok && q_r.enable;

    // Direction: external uses reverse, internal uses reference
    if (direction_source_jumper) begin
      want_dir = din.reverse;
    end else begin
      want_dir = ref_negative ^ ref_on_alt_terminal;
    end

    // Source select is a step, never ramped
    q_nxt.step = 1'b0;
    if (din.digital_sel != q_r.src) begin
      q_nxt.src  = din.digital_sel;
      q_nxt.step = (q_r.st != mrs_pkg::MRS_IDLE);
    end

    unique case (q_r.st)
      mrs_pkg::MRS_IDLE: begin
        q_nxt.latched = 1'b0;
        q_nxt.dir     = want_dir;
        if (din.run && can_run) begin
          q_nxt.st      = mrs_pkg::MRS_RUN;
          q_nxt.latched = din.hold;
          q_nxt.fault   = 1'b0;
        end
      end
      mrs_pkg::MRS_RUN, mrs_pkg::MRS_RAMP_STOP, mrs_pkg::MRS_REV_DECEL: begin
        // Once set, the latch only tracks hold; extra run closings change nothing
        q_nxt.latched = q_r.latched ? din.hold : (din.hold && din.run);
        if (!din.thermal_ok) begin
          q_nxt.st    = mrs_pkg::MRS_TRIP;
          q_nxt.fault = 1'b1;
          ev[`MRS_EV_THERMAL] = 1'b1;
        end else if (!din.estop_ok || !q_r.enable) begin
          q_nxt.st = mrs_pkg::MRS_IDLE;
          ev[`MRS_EV_ESTOP] = 1'b1;
        end else if (q_r.st == mrs_pkg::MRS_RAMP_STOP) begin
          if (at_zero_speed) begin
            q_nxt.st      = mrs_pkg::MRS_IDLE;
            q_nxt.latched = 1'b0;
            ev[`MRS_EV_STOPPED] = 1'b1;
          end
        end else if (q_r.latched && !din.hold) begin
          q_nxt.st = mrs_pkg::MRS_RAMP_STOP;
        end else if (!q_r.latched && !din.run && !din.hold) begin
          q_nxt.st = mrs_pkg::MRS_RAMP_STOP;
        end else if (q_r.st == mrs_pkg::MRS_REV_DECEL) begin
          if (at_zero_speed) begin
            q_nxt.dir = want_dir;
            q_nxt.st  = mrs_pkg::MRS_RUN;
          end
        end else if (want_dir != q_r.dir) begin
          if (direction_source_jumper) begin
            q_nxt.st = mrs_pkg::MRS_REV_DECEL;
            ev[`MRS_EV_REVERSE] = 1'b1;
          end else begin
            q_nxt.dir = want_dir;
          end
        end
      end
      mrs_pkg::MRS_TRIP: begin
        // Trip holds until the thermal closes and run is released
        q_nxt.latched = 1'b0;
        if (din.thermal_ok && !din.run) begin
          q_nxt.st = mrs_pkg::MRS_IDLE;
        end
      end
      default: q_nxt.st = mrs_pkg::MRS_IDLE;
    endcase

    // Drive requests, registered
    q_nxt.drv.drive_on     = (q_nxt.st == mrs_pkg::MRS_RUN) ||
                             (q_nxt.st == mrs_pkg::MRS_RAMP_STOP) ||
                             (q_nxt.st == mrs_pkg::MRS_REV_DECEL);
    q_nxt.drv.ramp_to_zero = (q_nxt.st == mrs_pkg::MRS_RAMP_STOP) ||
                             (q_nxt.st == mrs_pkg::MRS_REV_DECEL);
    q_nxt.drv.ramp_enable  = q_nxt.drv.drive_on && !q_nxt.step;
    q_nxt.drv.direction_rev      = q_nxt.dir;
    q_nxt.drv.speed_src_digital  = q_nxt.src;
    q_nxt.drv.current_limit_step = q_nxt.step;

    // Run node held active while operating
    q_nxt.fb = q_nxt.drv.drive_on;

    // Customer output: 01 run contact, 10 no-fault transistor
    unique case (customer_output_select_jumper)
      2'b01: begin
        q_nxt.cout = 1'b0;
        q_nxt.coe  = q_nxt.drv.drive_on;
      end
      2'b10: begin
        q_nxt.cout = 1'b0;
        q_nxt.coe  = !q_nxt.fault;
      end
      default: begin
        q_nxt.cout = 1'b0;
        q_nxt.coe  = 1'b0;
      end
    endcase

    // AXI write: take address and data in either order
    if (s_awvalid && !q_r.aw_ok && !q_r.bv) begin
      q_nxt.aw_ok = 1'b1;
      q_nxt.awa   = s_awaddr;
    end
    if (s_wvalid && !q_r.w_ok && !q_r.bv) begin
      q_nxt.w_ok = 1'b1;
      q_nxt.wd   = s_wdata;
      q_nxt.ws   = s_wstrb;
    end
    wr_go = q_r.aw_ok && q_r.w_ok;
    if (wr_go) begin
      q_nxt.aw_ok = 1'b0;
      q_nxt.w_ok  = 1'b0;
      q_nxt.bv    = 1'b1;
      q_nxt.br    = mapped(q_r.awa) ? 2'b00 : 2'b10;
      if (q_r.ws[0]) begin
        if (q_r.awa == `MRS_OFS_CTRL) begin
          q_nxt.enable = q_r.wd[`MRS_CTRL_ENABLE];
        end
        if (q_r.awa == `MRS_OFS_IRQ_MASK) begin
          q_nxt.imask = q_r.wd[3:0];
        end
      end
    end else if (q_r.bv && s_bready) begin
      q_nxt.bv = 1'b0;
    end

    // Sticky events: set wins over write-one-to-clear
    q_nxt.ist = q_r.ist;
    if (wr_go && q_r.ws[0] && (q_r.awa == `MRS_OFS_IRQ_STAT)) begin
      q_nxt.ist = q_r.ist & ~q_r.wd[3:0];
    end
    q_nxt.ist = q_nxt.ist | ev;
    q_nxt.irq = |(q_nxt.ist & q_nxt.imask);

    // AXI read
    if (s_arvalid && !q_r.rv) begin
      q_nxt.rv = 1'b1;
      q_nxt.rd = rd_word(s_araddr, q_r);
      q_nxt.rr = mapped(s_araddr) ? 2'b00 : 2'b10;
    end else if (q_r.rv && s_rready) begin
      q_nxt.rv = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r        <= '0;
      q_r.st     <= mrs_pkg::MRS_IDLE;
      q_r.enable <= 1'(`MRS_CTRL_RESET);
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign drive_on           = q_r.drv.drive_on;
  assign ramp_enable        = q_r.drv.ramp_enable;
  assign ramp_to_zero       = q_r.drv.ramp_to_zero;
  assign direction_rev      = q_r.drv.direction_rev;
  assign speed_src_digital  = q_r.drv.speed_src_digital;
  assign current_limit_step = q_r.drv.current_limit_step;
  assign run_feedback       = q_r.fb;
  assign run_feedback_oe    = q_r.fb;
  assign thermal_fault      = q_r.fault;
  assign customer_out       = q_r.cout;
  assign customer_out_oe    = q_r.coe;
  assign s_awready          = !q_r.aw_ok && !q_r.bv;
  assign s_wready           = !q_r.w_ok && !q_r.bv;
  assign s_bvalid           = q_r.bv;
  assign s_bresp            = q_r.br;
  assign s_arready          = !q_r.rv;
  assign s_rvalid           = q_r.rv;
  assign s_rdata            = q_r.rd;
  assign s_rresp            = q_r.rr;
  assign irq                = q_r.irq;

  // ==========================================================
  // Assertions
  a_run_needs_thermal: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && drive_on && !din.thermal_ok) |=> !drive_on)
    else $error("drive kept on with thermal open");
  a_thermal_trip: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && drive_on && !din.thermal_ok) |=> thermal_fault && !ramp_to_zero)
    else $error("thermal open did not trip");
  a_estop_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && !drive_on && !din.estop_ok) |=> !drive_on)
    else $error("started without emergency stop");
  a_estop_coast: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && drive_on && din.thermal_ok && !din.estop_ok) |=> !drive_on && !ramp_to_zero)
    else $error("emergency stop did not coast");
  a_hold_ramp: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && q_r.st == mrs_pkg::MRS_RUN && q_r.latched && !din.hold && din.thermal_ok
     && din.estop_ok && q_r.enable) |=> ramp_to_zero && drive_on)
    else $error("hold loss did not ramp");
  a_run_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && q_r.st == mrs_pkg::MRS_IDLE && din.run && din.thermal_ok && din.estop_ok
     && q_r.enable) |=> drive_on && ramp_enable && !ramp_to_zero)
    else $error("run did not start");
  a_feedback_run: assert property (@(posedge aclk) disable iff (!aresetn)
    run_feedback_oe == drive_on)
    else $error("run feedback not tied to operation");
  a_zero_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && q_r.st == mrs_pkg::MRS_RAMP_STOP && at_zero_speed && din.thermal_ok
     && din.estop_ok && q_r.enable) |=> !drive_on && !q_r.latched)
    else $error("ramped stop did not end");
  a_src_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && current_limit_step) |-> !ramp_enable)
    else $error("source step went through ramp");
  a_internal_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && !direction_source_jumper) |-> q_r.st != mrs_pkg::MRS_REV_DECEL
     || $past(q_r.st) == mrs_pkg::MRS_REV_DECEL)
    else $error("reverse acted in internal mode");
endmodule

/* File: sim/mrs_operator_model.sv */
`timescale 1ns/100ps
// ====================
// Operator station and ramp path stand-in
module mrs_operator_model #(
  parameter int ZERO_DELAY = 5
) (
  // Clock
  input  wire logic       aclk,
  // Requests from the sequencer
  input  wire logic       drive_on,
  input  wire logic       ramp_to_zero,
  // Contacts and ramp feedback
  output logic [5:0]      contacts,
  output logic            at_zero_speed
);
  int cnt = 0;

  // Contacts open at power-up
  initial contacts = 6'h00;

  // Order: thermal, estop, hold, run, source, reverse
  task automatic set_contacts(input logic [5:0] c);
    contacts <= c;
  endtask

  // Ramp needs several cycles to reach zero, so a stop is never instant
  always @(posedge aclk) begin
    if (!ramp_to_zero) cnt <= 0;
    else if (cnt < ZERO_DELAY) cnt <= cnt + 1;
  end
  assign at_zero_speed = !drive_on || (ramp_to_zero && cnt == ZERO_DELAY);
endmodule

/* File: sim/motor_run_stop_sequencer_tb.sv */
`timescale 1ns/100ps
module motor_run_stop_sequencer_tb;
  typedef struct packed {
    logic [5:0] c;
    logic [1:0] j;
    logic [3:0] e;
  } mrs_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        dir_j = 1'b1;
  logic [1:0]  cust_j = 2'b01;
  logic        ref_neg = 1'b0;
  logic        ref_alt = 1'b0;
  logic        cl_seen = 1'b0;
  logic [5:0]  contacts;
  logic        at_zero;
  logic        drive_on, ramp_enable, ramp_to_zero, direction_rev, speed_src_digital;
  logic        cl_step, run_fb, run_fb_oe, thermal_fault, customer_out, customer_out_oe;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic        s_arvalid = 1'b0, s_rready = 1'b0;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [1:0]  s_bresp, s_rresp, rsp;
  int          err_count = 0;
  int          checked = 0;
  int          n;
  wire  [31:0] outs = {28'h0, drive_on, speed_src_digital, customer_out_oe, direction_rev};
  wire  [31:0] flg = {28'h0, ramp_to_zero, thermal_fault, irq, run_fb_oe};
  wire  [31:0] aux = {28'h0, ramp_enable, run_fb, run_fb_oe, customer_out};
  // Contacts, jumper, expected {drive, source, customer, direction}
  mrs_row_t    rows [9] = '{
    '{6'b110000, 2'b10, 4'b0010}, '{6'b110100, 2'b01, 4'b1010},
    '{6'b110110, 2'b01, 4'b1110}, '{6'b110100, 2'b00, 4'b1000},
    '{6'b111100, 2'b01, 4'b1010}, '{6'b111000, 2'b01, 4'b1010},
    '{6'b101000, 2'b01, 4'b0000}, '{6'b100100, 2'b01, 4'b0000},
    '{6'b010100, 2'b01, 4'b0000}};

  // ====================
  // Design and partner
  mrs_sequencer #(.DEB_CYCLES(3)) mrs_sequencer_i (
    .aclk, .aresetn, .clk_en,
    .thermal_closed(contacts[5]), .estop_closed(contacts[4]), .hold_closed(contacts[3]),
    .run_closed(contacts[2]), .digital_select(contacts[1]), .reverse_select(contacts[0]),
    .direction_source_jumper(dir_j), .customer_output_select_jumper(cust_j),
    .ref_negative(ref_neg), .ref_on_alt_terminal(ref_alt), .at_zero_speed(at_zero),
    .drive_on, .ramp_enable, .ramp_to_zero, .direction_rev, .speed_src_digital,
    .current_limit_step(cl_step), .run_feedback(run_fb), .run_feedback_oe(run_fb_oe),
    .thermal_fault, .customer_out, .customer_out_oe,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .irq);
  mrs_operator_model #(.ZERO_DELAY(5)) mrs_operator_model_i (
    .aclk, .drive_on, .ramp_to_zero, .contacts, .at_zero_speed(at_zero));

  // ====================
  // Clock, pulse catcher, watchdog
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) if (cl_step) cl_seen <= 1'b1;
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    finish_test();
  end

  // ====================
  // Tasks
  task finish_test;
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Address and data offered together, each dropped once taken
  task axw(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_awready) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask
  task axr(input logic [11:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask
  task go(input logic [5:0] c, input int k);
    mrs_operator_model_i.set_contacts(c);
    cyc(k);
  endtask
  // Stop must pass through a driven ramp, then stay stopped without run
  task ramp_stop(input logic [5:0] c);
    go(6'b110000, 20);
    go(c, 20);
    mrs_operator_model_i.set_contacts(6'b110000);
    for (n = 0; n < 30 && ramp_to_zero !== 1'b1; n++) @(posedge aclk);
    chk(outs, 32'ha, "still driven while ramping");
    cyc(20);
    chk(outs, 32'h0, "stopped after ramp");
    go(6'b111000, 20);
    chk(outs, 32'h0, "hold alone restarted");
  endtask

  // ====================
  // Main sequence
  initial begin
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    chk(flg | outs, 32'h0, "outputs after reset");
    axr(12'h000);
    chk(rd, 32'h1, "control reset value");
    axr(12'h100);
    chk(32'(rsp), 32'h2, "unmapped read response");
    axw(12'h100, 32'h0);
    chk(32'(rsp), 32'h2, "unmapped write response");
    // A write without the low strobe must leave the enable alone
    s_wstrb <= 4'h0;
    axw(12'h000, 32'h0);
    chk(32'(rsp), 32'h0, "mapped write response");
    s_wstrb <= 4'hf;
    axr(12'h000);
    chk(rd, 32'h1, "write without low strobe");
    for (int i = 0; i < 9; i++) begin
      go(rows[i].c, 20);
      cust_j <= rows[i].j;
      cyc(2);
      chk(outs, 32'(rows[i].e), "row outputs");
      chk(aux, 32'(rows[i].e[3] ? 4'he : 4'h0), "run feedback");
    end
    ramp_stop(6'b111100);
    ramp_stop(6'b110100);
    axr(12'h008);
    chk(rd & 32'h4, 32'h4, "ramped stop event");
    // Thermal trip must coast and raise a maskable interrupt
    axw(12'h00c, 32'h1);
    axw(12'h008, 32'hf);
    go(6'b110100, 20);
    mrs_operator_model_i.set_contacts(6'b010100);
    for (n = 0; n < 30 && drive_on !== 1'b0; n++) @(posedge aclk);
    cyc(3);
    chk(flg, 32'h6, "coast with fault and irq");
    cust_j <= 2'b10;
    cyc(2);
    chk(32'(customer_out_oe), 32'h0, "no-fault output during fault");
    axw(12'h00c, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0, "masked irq");
    axw(12'h00c, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h1, "unmasked irq");
    axw(12'h008, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0, "cleared irq");
    cust_j <= 2'b01;
    go(6'b110000, 20);
    // Reverse in external mode decelerates first
    go(6'b110100, 20);
    mrs_operator_model_i.set_contacts(6'b110101);
    for (n = 0; n < 30 && ramp_to_zero !== 1'b1; n++) @(posedge aclk);
    chk(outs, 32'ha, "decel before reverse");
    cyc(20);
    chk(outs, 32'hb, "running reversed");
    dir_j <= 1'b0;
    cyc(5);
    chk(outs, 32'ha, "internal direction");
    go(6'b110100, 20);
    chk(outs, 32'ha, "reverse ignored");
    ref_alt <= 1'b1;
    cyc(5);
    chk(outs, 32'hb, "reference polarity");
    cl_seen <= 1'b0;
    go(6'b110110, 20);
    chk(outs | 32'(cl_seen) << 4, 32'h1f, "source step in current limit");
    // Low enable freezes all state, contacts included
    clk_en <= 1'b0;
    ref_neg <= 1'b1;
    go(6'b110000, 20);
    chk(outs, 32'hf, "state moved while frozen");
    clk_en <= 1'b1;
    cyc(40);
    chk(outs, 32'h0, "ramped stop after freeze");
    // Reset in mid-run drops drive at once, then a fresh start
    go(6'b110100, 20);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
    chk(flg | outs, 32'h0, "outputs after mid-run reset");
    cyc(20);
    chk(outs, 32'ha, "restart after reset");
    finish_test();
  end
endmodule
